// file: fb_bank_consts.svh
`ifndef FB_BANK_CONSTS_SVH
`define FB_BANK_CONSTS_SVH
// ==========================================================
// Register offsets (word index times four)
`define OFS_FB_POS 4'h0
`define OFS_FB_REV 4'h4
`define OFS_REF_POS 4'h8
`define OFS_REF_REV 4'hC
`define OFS_MODE 4'h0
`define OFS_CTRL_STAT 4'h4
// Upper address nibble selects the bank page
`define PAGE_ENC 4'h0
`define PAGE_DRV 4'h1
// ==========================================================
// Drive mode codes
`define MODE_OPEN_LOOP 16'h001A
`define MODE_CLOSED_VEC 16'h001B
`define MODE_SERVO 16'h001C
`define MODE_REGEN 16'h001D
// ==========================================================
// Control word fields
`define CW_ENABLE 0
`define CW_RUN_FWD 1
`define CW_JOG 2
`define CW_RUN_REV 3
`define CW_TRIP 4
`define CW_PRESET_LO 5
`define CW_PRESET_HI 6
`define CW_FLAG_ONE 7
`define CW_FLAG_TWO 8
`define CW_MASK_ENABLE 9
`define CW_MASK_RUN_FWD 10
`define CW_MASK_JOG 11
`define CW_MASK_RUN_REV 12
`define CW_FLAG_THREE 13
`define CW_MASK_PRESET_LO 14
`define CW_MASK_PRESET_HI 15
`define CW_MASK_OFS 9
`define FINE_LSB 0
`define FINE_MSB 15
`define COARSE_LSB 16
`define COARSE_MSB 31
`define STAT_UNUSED 15
`define ZERO16 16'h0000
`define ZERO32 32'h0000_0000
`define NUM_SEQ 4
`define SETTINGS_RST 6'h00
`define FLAGS_RST 3'h0
`endif

// file: fb_bank_pkg.sv
package fb_bank_pkg;
  // Encoder sample from the feedback logic
  typedef struct packed {
    logic [15:0] coarse;
    logic [15:0] fine;
    logic fine_valid;
    logic [15:0] revolutions;
  } encoder_s;
  // Actual drive mode
  typedef enum logic [1:0] {
    MODE_OPEN, MODE_VECTOR, MODE_SERVO, MODE_REGEN
  } drive_mode_e;
  // Drive settings driven by the control word
  typedef struct packed {
    logic preset_select_high;
    logic preset_select_low;
    logic run_reverse_setting;
    logic jog_setting;
    logic run_forward_setting;
    logic drive_enable_setting;
  } drive_settings_s;
  typedef struct packed {
    logic app_flag_three;
    logic app_flag_two;
    logic app_flag_one;
  } app_flags_s;
endpackage : fb_bank_pkg

// file: drive_feedback_status_control_bank.sv
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "fb_bank_consts.svh"
module drive_feedback_status_control_bank
  import fb_bank_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Feedback inputs from the drive
  input wire encoder_s fb_enc_i,
  input wire encoder_s ref_enc_i,
  input wire drive_mode_e mode_i,
  input wire logic [15:0] status_word_i,
  // Drive controls
  output drive_settings_s settings_o,
  output app_flags_s app_flags_o,
  output logic user_trip_o
);

  // ========================================================
  // Address decode
  wire logic [3:0] page = addr_i[7:4];
  wire logic [3:0] ofs = addr_i[3:0];
  wire logic sel_enc = (page == `PAGE_ENC);
  wire logic sel_drv = (page == `PAGE_DRV);
  wire logic ctrl_wr = wr_i && sel_drv && (ofs == `OFS_CTRL_STAT);

  // ========================================================
  // Position format; fine half forced to zero when not interpolated
  wire logic [31:0] fb_pos;
  wire logic [31:0] ref_pos;
  assign fb_pos[`COARSE_MSB:`COARSE_LSB] = fb_enc_i.coarse;
  assign fb_pos[`FINE_MSB:`FINE_LSB] = fb_enc_i.fine_valid ?
    fb_enc_i.fine : `ZERO16;
  assign ref_pos[`COARSE_MSB:`COARSE_LSB] = ref_enc_i.coarse;
  assign ref_pos[`FINE_MSB:`FINE_LSB] = ref_enc_i.fine_valid ?
    ref_enc_i.fine : `ZERO16;

  // Mode code, combinational so it is always current
  logic [15:0] mode_code;
  always_comb begin
    case (mode_i)
      MODE_OPEN: mode_code = `MODE_OPEN_LOOP;
      MODE_VECTOR: mode_code = `MODE_CLOSED_VEC;
      MODE_SERVO: mode_code = `MODE_SERVO;
      MODE_REGEN: mode_code = `MODE_REGEN;
      default: mode_code = `MODE_OPEN_LOOP;
    endcase
  end

  // Status with the unused top bit cleared
  wire logic [15:0] status_rd = {1'b0, status_word_i[`STAT_UNUSED-1:0]};

  // ========================================================
  // Read mux; unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = `ZERO32;
    if (sel_enc) begin
      case (ofs)
        `OFS_FB_POS: rd_mux = fb_pos;
        `OFS_FB_REV: rd_mux = {`ZERO16, fb_enc_i.revolutions};
        `OFS_REF_POS: rd_mux = ref_pos;
        `OFS_REF_REV: rd_mux = {`ZERO16, ref_enc_i.revolutions};
        default: rd_mux = `ZERO32;
      endcase
    end else if (sel_drv) begin
      case (ofs)
        `OFS_MODE: rd_mux = {`ZERO16, mode_code};
        `OFS_CTRL_STAT: rd_mux = {`ZERO16, status_rd};
        default: rd_mux = `ZERO32;
      endcase
    end
  end

  // Read data one cycle after the strobe, and only then
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= `ZERO32;
    end else begin
      rdata_o <= rd_i ? rd_mux : `ZERO32;
    end
  end

  // ========================================================
  // Masked settings; one generate per paired bit
  localparam int NSET = 6;
  localparam int VAL_IDX [NSET] = '{`CW_ENABLE, `CW_RUN_FWD, `CW_JOG,
    `CW_RUN_REV, `CW_PRESET_LO, `CW_PRESET_HI};
  localparam int MSK_IDX [NSET] = '{`CW_MASK_ENABLE, `CW_MASK_RUN_FWD,
    `CW_MASK_JOG, `CW_MASK_RUN_REV, `CW_MASK_PRESET_LO, `CW_MASK_PRESET_HI};
  logic [NSET-1:0] set_reg;
  logic [NSET-1:0] set_next;
  genvar gi;
  generate
    for (gi = 0; gi < NSET; gi++) begin : g_set
      // Clear mask leaves the setting alone
      assign set_next[gi] = (ctrl_wr && wdata_i[MSK_IDX[gi]]) ?
        wdata_i[VAL_IDX[gi]] : set_reg[gi];
    end
  endgenerate

  // All permitted updates land on the same edge
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      set_reg <= `SETTINGS_RST;
    end else begin
      set_reg <= set_next;
    end
  end
  assign settings_o = set_reg;

  // Unmasked flags
  app_flags_s flags_reg;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_reg <= `FLAGS_RST;
    end else if (ctrl_wr) begin
      flags_reg <= {wdata_i[`CW_FLAG_THREE], wdata_i[`CW_FLAG_TWO],
        wdata_i[`CW_FLAG_ONE]};
    end
  end
  assign app_flags_o = flags_reg;

  // Trip is a one-cycle pulse with no mask; the drive latches the trip
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      user_trip_o <= 1'b0;
    end else begin
      user_trip_o <= ctrl_wr && wdata_i[`CW_TRIP];
    end
  end

  // ========================================================
  // Checks
  property p_trip;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ctrl_wr && wdata_i[`CW_TRIP] |=> user_trip_o;
  endproperty
  a_trip: assert property (p_trip) else $error("trip missed");

  property p_no_trip;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !(ctrl_wr && wdata_i[`CW_TRIP]) |=> !user_trip_o;
  endproperty
  a_no_trip: assert property (p_no_trip)
    else $error("spurious trip");

  property p_enable_masked;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ctrl_wr && wdata_i[`CW_MASK_ENABLE] |=>
      settings_o.drive_enable_setting == $past(wdata_i[`CW_ENABLE]);
  endproperty
  a_enable_masked: assert property (p_enable_masked)
    else $error("enable not set");

  property p_hold;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !ctrl_wr |=> $stable(settings_o) && $stable(app_flags_o);
  endproperty
  a_hold: assert property (p_hold) else $error("setting moved");

  property p_mask_clear;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ctrl_wr && !wdata_i[`CW_MASK_PRESET_HI] |=>
      $stable(settings_o.preset_select_high);
  endproperty
  a_mask_clear: assert property (p_mask_clear)
    else $error("masked bit changed");

  property p_preset;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ctrl_wr && wdata_i[`CW_MASK_PRESET_LO] |=>
      settings_o.preset_select_low == $past(wdata_i[`CW_PRESET_LO]);
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset lo wrong");

  property p_flags;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ctrl_wr |=> app_flags_o.app_flag_three == $past(wdata_i[`CW_FLAG_THREE])
      && app_flags_o.app_flag_two == $past(wdata_i[`CW_FLAG_TWO])
      && app_flags_o.app_flag_one == $past(wdata_i[`CW_FLAG_ONE]);
  endproperty
  a_flags: assert property (p_flags) else $error("flag copy wrong");

  property p_status_read;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_i && sel_drv && ofs == `OFS_CTRL_STAT |=>
      rdata_o[15:0] == {1'b0, $past(status_word_i[14:0])};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read wrong");

  property p_mode_read;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_i && sel_drv && ofs == `OFS_MODE && mode_i == MODE_SERVO |=>
      rdata_o == {`ZERO16, `MODE_SERVO};
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("mode code wrong");

  property p_fine_zero;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_i && sel_enc && ofs == `OFS_FB_POS && !fb_enc_i.fine_valid |=>
      rdata_o[15:0] == 16'h0000;
  endproperty
  a_fine_zero: assert property (p_fine_zero)
    else $error("fine not zero");

  // ========================================================
  // Read path: every register against the inputs it shows
  // Read data falls back to zero so a stale word never lingers
  property p_rdata_idle;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !rd_i |=> rdata_o == `ZERO32;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not cleared");

  property p_fb_coarse;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_i && sel_enc && ofs == `OFS_FB_POS |=>
      rdata_o[`COARSE_MSB:`COARSE_LSB] == $past(fb_enc_i.coarse);
  endproperty
  a_fb_coarse: assert property (p_fb_coarse)
    else $error("feedback coarse wrong");

  property p_fb_fine;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_i && sel_enc && ofs == `OFS_FB_POS && fb_enc_i.fine_valid |=>
      rdata_o[`FINE_MSB:`FINE_LSB] == $past(fb_enc_i.fine);
  endproperty
  a_fb_fine: assert property (p_fb_fine)
    else $error("feedback fine wrong");

  property p_fb_revs;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_i && sel_enc && ofs == `OFS_FB_REV |=>
      rdata_o == {`ZERO16, $past(fb_enc_i.revolutions)};
  endproperty
  a_fb_revs: assert property (p_fb_revs)
    else $error("feedback turns wrong");

  property p_ref_coarse;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_i && sel_enc && ofs == `OFS_REF_POS |=>
      rdata_o[`COARSE_MSB:`COARSE_LSB] == $past(ref_enc_i.coarse);
  endproperty
  a_ref_coarse: assert property (p_ref_coarse)
    else $error("reference coarse wrong");

  property p_ref_fine_zero;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_i && sel_enc && ofs == `OFS_REF_POS && !ref_enc_i.fine_valid |=>
      rdata_o[`FINE_MSB:`FINE_LSB] == `ZERO16;
  endproperty
  a_ref_fine_zero: assert property (p_ref_fine_zero)
    else $error("reference fine not zero");

  property p_ref_revs;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_i && sel_enc && ofs == `OFS_REF_REV |=>
      rdata_o == {`ZERO16, $past(ref_enc_i.revolutions)};
  endproperty
  a_ref_revs: assert property (p_ref_revs)
    else $error("reference turns wrong");

  property p_mode_range;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_i && sel_drv && ofs == `OFS_MODE |=>
      rdata_o >= {`ZERO16, `MODE_OPEN_LOOP} &&
      rdata_o <= {`ZERO16, `MODE_REGEN};
  endproperty
  a_mode_range: assert property (p_mode_range)
    else $error("mode code out of range");

  property p_mode_regen;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_i && sel_drv && ofs == `OFS_MODE && mode_i == MODE_REGEN |=>
      rdata_o == {`ZERO16, `MODE_REGEN};
  endproperty
  a_mode_regen: assert property (p_mode_regen)
    else $error("regen code wrong");

  property p_stat_top;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_i && sel_drv && ofs == `OFS_CTRL_STAT |=> !rdata_o[`STAT_UNUSED];
  endproperty
  a_stat_top: assert property (p_stat_top)
    else $error("unused status bit set");

  // ========================================================
  // Control path: one check per masked setting
  // A swapped value or mask index in the table would trip these
  property p_run_fwd;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ctrl_wr && wdata_i[`CW_MASK_RUN_FWD] |=>
      settings_o.run_forward_setting == $past(wdata_i[`CW_RUN_FWD]);
  endproperty
  a_run_fwd: assert property (p_run_fwd)
    else $error("run forward not set");

  property p_jog;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ctrl_wr && wdata_i[`CW_MASK_JOG] |=>
      settings_o.jog_setting == $past(wdata_i[`CW_JOG]);
  endproperty
  a_jog: assert property (p_jog)
    else $error("jog not set");

  property p_run_rev;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ctrl_wr && wdata_i[`CW_MASK_RUN_REV] |=>
      settings_o.run_reverse_setting == $past(wdata_i[`CW_RUN_REV]);
  endproperty
  a_run_rev: assert property (p_run_rev)
    else $error("run reverse not set");

  property p_preset_hi;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ctrl_wr && wdata_i[`CW_MASK_PRESET_HI] |=>
      settings_o.preset_select_high == $past(wdata_i[`CW_PRESET_HI]);
  endproperty
  a_preset_hi: assert property (p_preset_hi)
    else $error("preset hi wrong");

  // Scenario covers
  c_trip: cover property (@(posedge ref_clk_i) user_trip_o);
  c_ctrl: cover property (@(posedge ref_clk_i) ctrl_wr ##[1:4] rd_i);
  c_pos: cover property (@(posedge ref_clk_i) rd_i && sel_enc);
  c_masked: cover property (@(posedge ref_clk_i)
    ctrl_wr && !wdata_i[`CW_MASK_ENABLE]);
  c_regen: cover property (@(posedge ref_clk_i)
    rd_i && sel_drv && mode_i == MODE_REGEN);
endmodule : drive_feedback_status_control_bank

// file: drive_model.sv
`timescale 1ns/1ns
// ==========================================================
// Host drive seen from the bank: feedback, mode, status
module drive_model
  import fb_bank_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Trip request from the bank
  input wire logic user_trip_i,
  // Values presented to the bank
  output encoder_s fb_enc_o,
  output encoder_s ref_enc_o,
  output drive_mode_e mode_o,
  output logic [15:0] status_word_o
);
  logic tripped_reg;
  logic [15:0] status_reg;

  // Quiet drive until the bench loads values
  initial begin
    fb_enc_o = '0;
    ref_enc_o = '0;
    mode_o = MODE_OPEN;
    status_reg = 16'h0000;
  end

  // New sample lands on a rising edge, like the drive
  task automatic load(input encoder_s fb, input encoder_s rf,
                      input drive_mode_e m, input logic [15:0] st);
    @(posedge ref_clk_i);
    fb_enc_o <= fb;
    ref_enc_o <= rf;
    mode_o <= m;
    status_reg <= st;
  endtask : load

  // Trip pulse is latched; only a reset clears it
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tripped_reg <= 1'b0;
    end else if (user_trip_i) begin
      tripped_reg <= 1'b1;
    end
  end

  // A tripped drive no longer reports healthy
  assign status_word_o = status_reg & {15'h7FFF, ~tripped_reg};
endmodule : drive_model

// file: tb.sv
`timescale 1ns/1ns
// ==========================================================
// Register bank bench
module tb;
  import fb_bank_pkg::*;
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
  errors++; $display("wrong value %s exp %h got %h", n, e, s); end end
  logic clk, rst_n, wr, rd, user_trip;
  logic [7:0] addr;
  logic [15:0] wdata, status_word;
  logic [31:0] rdata;
  encoder_s fb_enc, ref_enc, fb, rf;
  drive_mode_e mode;
  drive_settings_s settings;
  app_flags_s app_flags;
  int errors, num_checks;
  logic [15:0] cw [5] = '{16'hFFEF, 16'h0000, 16'h0200, 16'h8000, 16'h0010};
  logic [5:0] exp_set [5] = '{6'h3F, 6'h3F, 6'h3E, 6'h1E, 6'h1E};
  logic [2:0] exp_flg [5] = '{3'h7, 3'h0, 3'h0, 3'h0, 3'h0};

  drive_feedback_status_control_bank drive_feedback_status_control_bank_i (
    .ref_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .fb_enc_i(fb_enc),
    .ref_enc_i(ref_enc), .mode_i(mode), .status_word_i(status_word),
    .settings_o(settings), .app_flags_o(app_flags),
    .user_trip_o(user_trip));
  drive_model drive_model_i (
    .ref_clk_i(clk), .rst_n_i(rst_n), .user_trip_i(user_trip),
    .fb_enc_o(fb_enc), .ref_enc_o(ref_enc), .mode_o(mode),
    .status_word_o(status_word));

  // Free-running 125 MHz clock
  always #4 clk = ~clk;

  // One-cycle write; settles past the sampling edge on return
  task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_word

  // One-cycle read; data stands only in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask : rd_chk

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // Run is about fifty cycles; far longer means a hang
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    test_done();
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {addr, wdata, wr, rd} = '0;
    errors = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK("settings", 6'h00, settings)
    fb = encoder_s'({16'h1234, 16'hABCD, 1'b1, 16'h0042});
    rf = encoder_s'({16'h8765, 16'h5A5A, 1'b0, 16'hFFFE});
    drive_model_i.load(fb, rf, MODE_OPEN, 16'hFFFF);
    rd_chk(8'h00, 32'h1234ABCD);
    rd_chk(8'h04, 32'h0000_0042);
    rd_chk(8'h08, 32'h8765_0000);
    rd_chk(8'h0C, 32'h0000_FFFE);
    rd_chk(8'h14, 32'h0000_7FFF);
    // Plain encoder: coarse follows the count, fine reads zero
    fb = encoder_s'({16'h0F0F, 16'h9999, 1'b0, 16'h0043});
    drive_model_i.load(fb, rf, MODE_OPEN, 16'hFFFF);
    rd_chk(8'h00, 32'h0F0F_0000);
    // Every mode code, read right after the drive changes mode
    for (int i = 0; i < 4; i++) begin
      drive_model_i.load(fb, rf, drive_mode_e'(i), 16'hFFFF);
      rd_chk(8'h10, 32'(26 + i));
    end
    // Masked and unmasked control writes, trip last
    for (int i = 0; i < 5; i++) begin
      wr_word(8'h14, cw[i]);
      `CHK("settings", exp_set[i], settings)
      `CHK("flags", exp_flg[i], app_flags)
      `CHK("trip", (i == 4), user_trip)
    end
    // Trip is a pulse: gone one cycle after the write landed
    @(posedge clk);
    #1;
    `CHK("trip", 1'b0, user_trip)
    rd_chk(8'h14, 32'h0000_7FFE);
    // Writes elsewhere are ignored; unmapped reads give zero
    wr_word(8'h00, 16'hFFEF);
    `CHK("settings", 6'h1E, settings)
    rd_chk(8'h20, 32'h0000_0000);
    test_done();
  end
endmodule : tb
